// >>> bench/audio_source.sv
`timescale 1ns/1ns
// Coded byte source answering the request on the device's bit clock
module audio_source (
	input  wire logic        i_bit_clk,
	input  wire logic        i_request,
	input  wire logic [31:0] i_frame,
	input  wire logic [7:0]  i_delay,
	output logic             o_data,
	output logic             o_valid,
	output logic             o_err,
	output logic             o_sync
);
	logic       req_seen;	// Request as sampled on rise
	logic [4:0] pos;	// Bit position in frame
	int         wait_cnt;	// Late start counter

	initial begin
		{o_data, o_valid, o_err, o_sync, pos, req_seen} = '0;
		wait_cnt = 0;
	end

	// Sample request on the rising edge
	always @(posedge i_bit_clk) begin
		req_seen <= i_request;
	end

	// Drive on fall; whole bytes, back to back while requested
	always @(negedge i_bit_clk) begin
		if ((req_seen && wait_cnt >= int'(i_delay)) || pos[2:0] != 3'h0) begin
			o_valid <= 1'b1;
			o_data  <= i_frame[5'h1F - pos];
			o_sync  <= (pos == 5'h00);	// Frame start marker
			pos     <= pos + 5'h01;
		end else begin
			o_valid <= 1'b0;
			o_data  <= ~o_data;	// Idle data toggles, never stale
			o_sync  <= 1'b0;
		end
		wait_cnt <= req_seen ? wait_cnt + 1 : 0;
	end
endmodule

// >>> bench/coded_audio_input_frame_sync_bench.sv
`timescale 1ns/1ns
`include "frame_sync_defs.svh"
// Register and link bench for the frame sync block
module coded_audio_input_frame_sync_bench;
	import frame_sync_pkg::*;
	logic        i_core_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic [11:0] i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata, rd_data, frame;
	logic [3:0]  i_wstrb;
	logic [1:0]  o_bresp, o_rresp, resp;
	logic [7:0]  delay;
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, i_coded_bit_clock;
	logic        i_coded_bit_in, i_coded_bit_valid, i_coded_bit_error_attr, i_coded_sync_marker;
	logic        o_coded_bit_clock, o_coded_bit_clock_oe, o_coded_data_request;
	logic        o_decode_enable, o_audio_mute, o_frame_start;
	int          mismatches, checked, k, cnt;

	coded_audio_input_frame_sync #(
		.TIMEOUT_CYCLES(600)
	) dut (
		.i_core_clk, .i_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
		.i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
		.o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_coded_bit_in,
		.i_coded_bit_valid, .i_coded_bit_error_attr, .i_coded_sync_marker,
		.i_coded_bit_clock, .o_coded_bit_clock, .o_coded_bit_clock_oe,
		.o_coded_data_request, .o_decode_enable, .o_audio_mute, .o_frame_start
	);

	audio_source source (
		.i_bit_clk(o_coded_bit_clock), .i_request(o_coded_data_request),
		.i_frame(frame), .i_delay(delay), .o_data(i_coded_bit_in),
		.o_valid(i_coded_bit_valid), .o_err(i_coded_bit_error_attr),
		.o_sync(i_coded_sync_marker)
	);

	// 100 MHz core clock
	always #5 i_core_clk = ~i_core_clk;

	// Counts, verdict, end of run
	task print_verdict;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// A wait that ran out ends the run
	task timed_out;
		mismatches++;
		$display("BAD %0t wait ran out", $time);
		print_verdict();
	endtask

	// AXI4-Lite write, address and data offered together
	task axi_wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge i_core_clk);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge i_core_clk);
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
			if (o_bvalid) break;
		end
		if (n == 50) timed_out();
		resp = o_bresp;
		i_bready <= 1'b0;
	endtask

	// AXI4-Lite read
	task axi_rd(input logic [11:0] a);
		int n;
		@(posedge i_core_clk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge i_core_clk);
			if (o_arready) i_arvalid <= 1'b0;
			if (o_rvalid) break;
		end
		if (n == 50) timed_out();
		rd_data = o_rdata;
		resp = o_rresp;
		i_rready <= 1'b0;
	endtask

	// Wait for frame start, lock, clock change, request or idle link; cnt gets the cycles
	task wait_for(input int sel, input int n);
		int  i;
		logic last;
		last = o_coded_bit_clock;
		for (i = 0; i < n; i++) begin
			@(posedge i_core_clk);
			if (sel == 0 && o_frame_start === 1'b1) break;
			if (sel == 1 && o_decode_enable === 1'b1) break;
			if (sel == 2 && o_coded_bit_clock !== last) break;
			if (sel == 3 && o_coded_data_request === 1'b1) break;
			if (sel == 4 && o_coded_data_request === 1'b0 && i_coded_bit_valid === 1'b0) break;
		end
		if (i == n) timed_out();
		cnt = i + 1;
	endtask

	// Leave input mode first so the new setting restarts sync and fill
	task set_ctrl(input logic [31:0] v);
		axi_wr(`OFS_CTRL, 32'h0);
		axi_wr(`OFS_CTRL, v);
		chk(resp, 2'h0);
	endtask

	// Main sequence
	initial begin
		{i_core_clk, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
		{i_awaddr, i_araddr, i_wdata, i_coded_bit_clock} = '0;
		i_rst = 1'b1;
		i_wstrb = 4'hF;
		frame = 32'hFFF40000;
		delay = 8'h00;
		mismatches = 0;
		checked = 0;
		repeat (20) @(posedge i_core_clk);
		i_rst <= 1'b0;
		repeat (2) @(posedge i_core_clk);
		chk(o_audio_mute, 1'b1);
		chk(o_decode_enable, 1'b0);
		chk(o_coded_data_request, 1'b0);
		chk(o_coded_bit_clock_oe, 1'b0);
		axi_rd(`OFS_CTRL);
		chk(rd_data, `CTRL_RESET_VALUE);
		axi_rd(12'h010);
		chk(resp, 2'h2);
		axi_wr(`OFS_FRAME_LEN, 32'h20);
		axi_rd(`OFS_FRAME_LEN);
		chk(rd_data[15:0], 16'h0020);
		chk(resp, 2'h0);
		axi_wr(12'h010, 32'h0);
		chk(resp, 2'h2);
		// Both buffered modes, both clock ratios
		for (k = 0; k < 2; k++) begin
			set_ctrl(32'h2 + k + (k << 4));
			wait_for(3, 200);
			chk(o_coded_bit_clock_oe, 1'b1);
			wait_for(2, 100);
			wait_for(2, 100);
			chk(cnt, k ? 16 : 8);
		end
		// Lock in every sync mode; a late source in general mode
		for (k = 0; k < 5; k++) begin
			delay = (k == 0) ? 8'h28 : 8'h00;
			set_ctrl(32'h2 + ((k % 4) << 2) + ((k == 3) << 5));
			wait_for(0, 6000);
			repeat (4) @(posedge i_core_clk);
			chk(o_decode_enable, k == 3);
			wait_for(1, 6000);
			chk(o_audio_mute, 1'b0);
		end
		// Mode 01 ignores pulses; a wrong frame length fails checking
		for (k = 0; k < 2; k++) begin
			frame = k ? 32'hFFF40000 : 32'h0;
			axi_wr(`OFS_FRAME_LEN, k ? 32'h28 : 32'h20);
			// Source idle on a byte boundary before the clock stops
			wait_for(4, 8000);
			set_ctrl(32'h6);
			repeat (4000) @(posedge i_core_clk);
			chk(o_decode_enable, 1'b0);
			chk(o_coded_data_request, 1'b0);
			axi_rd(`OFS_STATUS);
			// One byte already launched when the request drops
			chk(rd_data[11:4], `FILL_THRESHOLD + 8'h01);
		end
		print_verdict();
	end
endmodule

// >>> bench/frame_sync_checker.sv
`timescale 1ns/1ns
// Port-level watch on the frame sync block
module frame_sync_checker
	import frame_sync_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = 200
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic o_rvalid,
	input wire logic o_bvalid,
	input wire logic o_awready,
	input wire logic o_coded_bit_clock,
	input wire logic o_coded_bit_clock_oe,
	input wire logic o_coded_data_request,
	input wire logic o_decode_enable,
	input wire logic o_audio_mute,
	input wire logic o_frame_start
);
	logic seen_start;	// Frame start seen since reset

	// Remember the first accepted frame start
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			seen_start <= 1'b0;
		end else if (o_frame_start) begin
			seen_start <= 1'b1;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	a_mute_follows_lock: assert property (o_audio_mute == !o_decode_enable)
		else $error("mute does not mirror decode enable");
	a_clk_half_hold: assert property ($changed(o_coded_bit_clock) && o_coded_bit_clock_oe
		|=> ($stable(o_coded_bit_clock) || !o_coded_bit_clock_oe)[*7])
		else $error("bit clock half period too short");
	a_clk_keeps_moving: assert property (o_coded_bit_clock_oe
		|-> ##[1:16] ($changed(o_coded_bit_clock) || !o_coded_bit_clock_oe))
		else $error("bit clock stalled");
	a_req_rise_low: assert property ($rose(o_coded_data_request) |-> !o_coded_bit_clock)
		else $error("request rose outside the low clock phase");
	a_req_in_buffered: assert property ($rose(o_coded_data_request) |-> o_coded_bit_clock_oe)
		else $error("request outside buffered mode");
	a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
		else $error("read data late");
	a_read_busy: assert property (o_rvalid |-> !o_arready)
		else $error("read address taken during answer");
	a_write_busy: assert property (o_bvalid |-> !o_awready)
		else $error("write address taken during answer");
	a_lock_after_start: assert property ($rose(o_decode_enable) |-> seen_start || o_frame_start)
		else $error("decoding began before a frame start");

	c_lock: cover property ($rose(o_decode_enable));
	c_request: cover property ($rose(o_coded_data_request));
	c_frame: cover property (o_frame_start);
endmodule

bind coded_audio_input_frame_sync frame_sync_checker #(
	.TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) watch (
	.i_core_clk, .i_rst, .i_arvalid, .o_arready, .o_rvalid, .o_bvalid, .o_awready,
	.o_coded_bit_clock, .o_coded_bit_clock_oe, .o_coded_data_request,
	.o_decode_enable, .o_audio_mute, .o_frame_start
);

// >>> hdl/bit_clock_gen.sv
`timescale 1ns/1ns
`include "frame_sync_defs.svh"

// Divides the core clock to drive the coded-data bit clock
module bit_clock_gen
	import frame_sync_pkg::*;
(
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	input  wire logic i_enable,
	input  wire logic i_ratio,
	output logic      o_clk,
	output logic      o_rise,
	output logic      o_fall
);

	typedef struct packed {
		logic [4:0] cnt;
		logic       level;
	} div_st_t;

	div_st_t    st_reg;  // Registered state
	div_st_t    st_next; // Next state
	logic [4:0] half;    // Half period length
	logic       wrap;    // Half period end

	// Divide by 32 or 16 of the core clock
	always_comb begin
		half     = i_ratio ? `DIV_HALF_RATIO1 : `DIV_HALF_RATIO0;
		wrap     = (st_reg.cnt == half - 5'h01);
		st_next  = st_reg;
		if (!i_enable) begin
			st_next = '0;
		end else if (wrap) begin
			st_next.cnt   = 5'h00;
			st_next.level = ~st_reg.level;
		end else begin
			st_next.cnt = st_reg.cnt + 5'h01;
		end
	end

	// State register
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_clk  = st_reg.level;
	assign o_rise = i_enable && wrap && !st_reg.level;
	assign o_fall = i_enable && wrap && st_reg.level;

endmodule

// >>> hdl/coded_audio_input_frame_sync.sv
`timescale 1ns/1ns
`include "frame_sync_defs.svh"
module coded_audio_input_frame_sync
	import frame_sync_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	// AXI4-Lite slave
	input  wire logic [11:0] i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [11:0] i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	// Coded data link
	input  wire logic        i_coded_bit_in,
	input  wire logic        i_coded_bit_valid,
	input  wire logic        i_coded_bit_error_attr,
	input  wire logic        i_coded_sync_marker,
	input  wire logic        i_coded_bit_clock,
	output logic             o_coded_bit_clock,
	output logic             o_coded_bit_clock_oe,
	output logic             o_coded_data_request,
	// Decoder side
	output logic             o_decode_enable,
	output logic             o_audio_mute,
	output logic             o_frame_start
);

	// Whole module state
	typedef struct packed {
		ctrl_t       ctrl;        // Control fields
		logic        clk_d;       // Previous bit clock level
		logic        sync_d;      // Previous sync level
		logic        sync_pend;   // Sync edge awaiting valid bit
		logic [14:0] shreg;       // Pattern shift register
		logic [2:0]  bit_cnt;     // Bit in byte
		logic [7:0]  byte_sh;     // Byte assembly
		logic        byte_err;    // Combined error for byte
		logic [7:0]  rx_byte;     // Last byte
		logic        rx_err;      // Error of last byte
		logic [7:0]  fill;        // Buffer occupancy in bytes
		logic [15:0] drain_cnt;   // Decoder consumption timer
		logic        req;         // Request output
		sync_state_t state;       // Sync phase
		logic        pat_sel;     // Which pattern in general mode
		logic [15:0] frame_bits;  // Software frame length
		logic [15:0] frame_cnt;   // Bits into current frame
		logic [1:0]  verify_left; // Frames still to verify
		logic [31:0] timeout;     // Search time-out
		logic        fstart;      // Frame start pulse
		logic        aw_got;      // Write address held
		logic        w_got;       // Write data held
		logic [11:0] awaddr;      // Held write address
		logic [31:0] wdata;       // Held write data
		logic        bvalid;      // Write response pending
		logic        bad_w;       // Unmapped write
		logic        rvalid;      // Read data pending
		logic [31:0] rdata;       // Read data
		logic        bad_r;       // Unmapped read
	} core_st_t;

	core_st_t   st_reg;   // Registered state
	core_st_t   st_next;  // Next state
	link_bits_t pins;     // Synchronised link inputs
	logic       ext_clk;  // Synchronised external bit clock
	logic       gen_clk;  // Generated bit clock
	logic       gen_rise; // Generated rising edge
	logic       gen_fall; // Generated falling edge
	logic       buffered; // Buffer-controlled mode active
	logic       rise;     // Sampling moment
	logic       fall;     // Request update moment
	logic       vbit;     // Valid bit sampled
	logic       sy_edge;  // Sync rising edge at sampling
	logic       hit;      // Pattern match
	logic       fend;     // Frame length reached
	logic [1:0] vlen;     // Verification length
	logic       mode_chg; // Input mode written differently
	logic       new_byte; // Byte finished this sample

	// Link input synchronisers
	pin_sync u_sync_data (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_pin      (i_coded_bit_in),
		.o_level    (pins.data)
	);
	pin_sync u_sync_valid (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_pin      (i_coded_bit_valid),
		.o_level    (pins.valid)
	);
	pin_sync u_sync_err (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_pin      (i_coded_bit_error_attr),
		.o_level    (pins.err)
	);
	pin_sync u_sync_sy (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_pin      (i_coded_sync_marker),
		.o_level    (pins.sync)
	);
	pin_sync u_sync_clk (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_pin      (i_coded_bit_clock),
		.o_level    (ext_clk)
	);

	assign buffered = st_reg.ctrl.input_mode[`INMODE_BUFFERED_BIT];

	// Bit clock driver used in buffered mode
	bit_clock_gen u_clkgen (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_enable   (buffered),
		.i_ratio    (st_reg.ctrl.clk_ratio),
		.o_clk      (gen_clk),
		.o_rise     (gen_rise),
		.o_fall     (gen_fall)
	);

	// Main next-state logic
	always_comb begin
		st_next        = st_reg;
		st_next.fstart = 1'b0;
		// Edges of the chosen bit clock
		rise     = buffered ? gen_rise : (ext_clk && !st_reg.clk_d);
		fall     = buffered ? gen_fall : (!ext_clk && st_reg.clk_d);
		st_next.clk_d = ext_clk;
		vbit     = rise && pins.valid;
		sy_edge  = rise && pins.sync && !st_reg.sync_d;
		new_byte = 1'b0;
		hit      = 1'b0;
		fend     = 1'b0;
		mode_chg = 1'b0;
		// Verification length by CRC and free format
		unique case ({st_reg.ctrl.crc_on, st_reg.ctrl.free_fmt})
			2'b00:   vlen = 2'h1;
			2'b01:   vlen = 2'h2;
			2'b10:   vlen = 2'h0;
			2'b11:   vlen = 2'h1;
		endcase
		if (rise) begin
			st_next.sync_d = pins.sync;
		end
		// Sync edge remembered until a valid bit arrives
		if (sy_edge) begin
			st_next.sync_pend = 1'b1;
		end
		if (vbit) begin
			st_next.shreg    = {st_reg.shreg[13:0], pins.data};
			st_next.byte_sh  = {st_reg.byte_sh[6:0], pins.data};
			st_next.byte_err = st_reg.byte_err | pins.err;
			st_next.bit_cnt  = st_reg.bit_cnt + 3'h1;
			st_next.frame_cnt = st_reg.frame_cnt + 16'h0001;
			// Byte alignment from sync edge
			if ((st_reg.sync_pend || sy_edge)
				&& st_reg.ctrl.sync_mode == `SYNC_BYTE_ALIGNED) begin
				st_next.byte_sh  = {7'h00, pins.data};
				st_next.byte_err = pins.err;
				st_next.bit_cnt  = 3'h1;
			end else if (st_reg.bit_cnt == 3'h7) begin
				new_byte = 1'b1;
			end
			st_next.sync_pend = 1'b0;
			// Frame start detection per mode
			unique case (st_reg.ctrl.sync_mode)
				`SYNC_PULSE: hit = st_reg.sync_pend || sy_edge;
				`SYNC_LAYER2: hit = (({st_reg.shreg[13:0], pins.data}
					& `PAT_A_MASK) == `PAT_A_VALUE);
				`SYNC_GENERAL: hit = st_reg.pat_sel ?
					(({st_reg.shreg[13:0], pins.data} & `PAT_B_MASK) == `PAT_B_VALUE) :
					(({st_reg.shreg[13:0], pins.data} & `PAT_A_MASK) == `PAT_A_VALUE);
				`SYNC_BYTE_ALIGNED: hit = (({st_reg.shreg[13:0], pins.data}
					& `PAT_A_MASK) == `PAT_A_VALUE) && (st_reg.bit_cnt == 3'h6);
			endcase
			fend = (st_reg.frame_cnt == st_reg.frame_bits - 16'h0001);
		end
		if (new_byte) begin
			st_next.rx_byte  = st_next.byte_sh;
			st_next.rx_err   = st_next.byte_err;
			st_next.byte_err = 1'b0;
		end
		// Sync search, verification and lock
		unique case (st_reg.state)
			SEARCH: begin
				if (hit) begin
					st_next.frame_cnt   = 16'h0000;
					st_next.fstart      = 1'b1;
					st_next.timeout     = '0;
					st_next.verify_left = vlen;
					st_next.state       = (vlen == 2'h0) ? LOCKED : VERIFY;
				end else if (st_reg.ctrl.sync_mode == `SYNC_GENERAL) begin
					// Alternate pattern on time-out
					if (st_reg.timeout == TIMEOUT_CYCLES[31:0] - 32'h1) begin
						st_next.timeout = '0;
						st_next.pat_sel = ~st_reg.pat_sel;
					end else begin
						st_next.timeout = st_reg.timeout + 32'h1;
					end
				end
			end
			VERIFY, LOCKED: begin
				if (fend) begin
					st_next.frame_cnt = 16'h0000;
					st_next.fstart    = hit;
					if (!hit) begin
						st_next.state = SEARCH;
					end else if (st_reg.state == VERIFY) begin
						st_next.verify_left = st_reg.verify_left - 2'h1;
						if (st_reg.verify_left == 2'h1) begin
							st_next.state = LOCKED;
						end
					end
				end
			end
			default: st_next.state = SEARCH;
		endcase
		// Buffer occupancy: bytes in, decoder drains at fixed pace
		st_next.drain_cnt = st_reg.drain_cnt + 16'h0001;
		if (st_reg.drain_cnt == `BUFFER_DRAIN_CYCLES - 16'h0001) begin
			st_next.drain_cnt = 16'h0000;
		end
		if (new_byte && st_reg.fill != 8'hFF) begin
			st_next.fill = st_reg.fill + 8'h01;
		end
		if (st_reg.drain_cnt == `BUFFER_DRAIN_CYCLES - 16'h0001
			&& st_reg.state == LOCKED && st_next.fill != 8'h00) begin
			st_next.fill = st_next.fill - 8'h01;
		end
		// Request updated on falling bit clock edge
		if (fall) begin
			st_next.req = buffered && (st_reg.fill < `FILL_THRESHOLD);
		end
		if (!buffered) begin
			st_next.req = 1'b0;
		end
		// AXI4-Lite write channel
		if (i_awvalid && !st_reg.aw_got && !st_reg.bvalid) begin
			st_next.aw_got = 1'b1;
			st_next.awaddr = i_awaddr;
		end
		if (i_wvalid && !st_reg.w_got && !st_reg.bvalid) begin
			st_next.w_got = 1'b1;
			st_next.wdata = i_wdata;
		end
		if (st_reg.aw_got && st_reg.w_got) begin
			st_next.aw_got = 1'b0;
			st_next.w_got  = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bad_w  = 1'b0;
			unique case (st_reg.awaddr)
				`OFS_CTRL: begin
					// Mode fields written by software
					st_next.ctrl = st_reg.wdata[6:0];
					mode_chg = (st_reg.wdata[1:0] != st_reg.ctrl.input_mode);
				end
				`OFS_FRAME_LEN: st_next.frame_bits = st_reg.wdata[15:0];
				`OFS_STATUS, `OFS_RX_DATA: st_next.bad_w = 1'b0;
				default: st_next.bad_w = 1'b1;
			endcase
		end
		if (st_reg.bvalid && i_bready) begin
			st_next.bvalid = 1'b0;
		end
		// AXI4-Lite read channel
		if (i_arvalid && !st_reg.rvalid) begin
			st_next.rvalid = 1'b1;
			st_next.bad_r  = 1'b0;
			unique case (i_araddr)
				`OFS_CTRL:      st_next.rdata = {25'h0, st_reg.ctrl};
				`OFS_STATUS:    st_next.rdata = {20'h0, st_reg.fill, st_reg.req,
					st_reg.pat_sel, st_reg.state};
				`OFS_FRAME_LEN: st_next.rdata = {16'h0, st_reg.frame_bits};
				`OFS_RX_DATA:   st_next.rdata = {23'h0, st_reg.rx_err, st_reg.rx_byte};
				default: begin
					st_next.rdata = 32'h0000_0000;
					st_next.bad_r = 1'b1;
				end
			endcase
		end
		if (st_reg.rvalid && i_rready) begin
			st_next.rvalid = 1'b0;
		end
		// Input mode change acts as soft reset of the datapath
		if (mode_chg) begin
			st_next.state     = SEARCH;
			st_next.fill      = 8'h00;
			st_next.req       = 1'b0;
			st_next.bit_cnt   = 3'h0;
			st_next.frame_cnt = 16'h0000;
			st_next.timeout   = '0;
		end
	end

	// State register
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_reg            <= '0;
			st_reg.ctrl       <= 7'(`CTRL_RESET_VALUE);
			st_reg.frame_bits <= `DEFAULT_FRAME_BITS;
			st_reg.state      <= SEARCH;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs
	assign o_awready            = !st_reg.aw_got && !st_reg.bvalid;
	assign o_wready             = !st_reg.w_got && !st_reg.bvalid;
	assign o_bvalid             = st_reg.bvalid;
	assign o_bresp              = st_reg.bad_w ? 2'h2 : 2'h0;
	assign o_arready            = !st_reg.rvalid;
	assign o_rvalid             = st_reg.rvalid;
	assign o_rdata              = st_reg.rdata;
	assign o_rresp              = st_reg.bad_r ? 2'h2 : 2'h0;
	assign o_coded_bit_clock    = gen_clk;
	assign o_coded_bit_clock_oe = buffered;
	assign o_coded_data_request = st_reg.req;
	assign o_decode_enable      = (st_reg.state == LOCKED);
	assign o_audio_mute         = (st_reg.state != LOCKED);
	assign o_frame_start        = st_reg.fstart;

endmodule

// >>> hdl/frame_sync_defs.svh
`ifndef FRAME_SYNC_DEFS_SVH
`define FRAME_SYNC_DEFS_SVH

// Register byte offsets
`define OFS_CTRL            12'h000
`define OFS_STATUS          12'h004
`define OFS_FRAME_LEN       12'h008
`define OFS_RX_DATA         12'h00C

// Control register field positions
`define CTRL_INPUT_MODE_LSB  0
`define CTRL_SYNC_MODE_LSB   2
`define CTRL_CLK_RATIO_BIT   4
`define CTRL_CRC_BIT         5
`define CTRL_FREE_FMT_BIT    6
`define CTRL_RESET_VALUE     32'h0000_0000

// Field encodings
`define INMODE_BUFFERED_BIT  1
`define SYNC_GENERAL         2'h0
`define SYNC_LAYER2          2'h1
`define SYNC_BYTE_ALIGNED    2'h2
`define SYNC_PULSE           2'h3

// Sync patterns, 15 bits, with don't-care masks
`define PAT_A_VALUE          15'h7FFA
`define PAT_A_MASK           15'h7FFB
`define PAT_B_VALUE          15'h0FFD
`define PAT_B_MASK           15'h1FFD
`define PAT_WIDTH            15

// Bit clock dividers: half periods in core cycles
`define DIV_HALF_RATIO1      5'h10
`define DIV_HALF_RATIO0      5'h08

// Input buffer fill threshold in bytes
`define FILL_THRESHOLD       8'h10
`define BUFFER_DRAIN_CYCLES  16'h0100

// Time-out slightly above the longest frame
`define TIMEOUT_MS           73
`define CLK_MHZ              100
`define TIMEOUT_CYCLES       (`TIMEOUT_MS * 1000 * `CLK_MHZ)
`define DEFAULT_FRAME_BITS   16'h0C00

`endif

// >>> hdl/frame_sync_pkg.sv
package frame_sync_pkg;

	// Sampled inputs from the link, one bundle
	typedef struct packed {
		logic data;
		logic valid;
		logic err;
		logic sync;
	} link_bits_t;

	// Software control fields
	typedef struct packed {
		logic       free_fmt;
		logic       crc_on;
		logic       clk_ratio;
		logic [1:0] sync_mode;
		logic [1:0] input_mode;
	} ctrl_t;

	// Frame sync search phases
	typedef enum logic [1:0] {
		SEARCH,
		VERIFY,
		LOCKED
	} sync_state_t;

endpackage

// >>> hdl/pin_sync.sv
`timescale 1ns/1ns
`include "frame_sync_defs.svh"

// Three-stage synchroniser; a change counts once stages two and three agree
module pin_sync
	import frame_sync_pkg::*;
(
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	input  wire logic i_pin,
	output logic      o_level
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} sync_st_t;

	sync_st_t st_reg;  // Registered state
	sync_st_t st_next; // Next state

	// Shift chain and agreement filter
	always_comb begin
		st_next     = st_reg;
		st_next.s1  = i_pin;
		st_next.s2  = st_reg.s1;
		st_next.s3  = st_reg.s2;
		if (st_reg.s2 == st_reg.s3) begin
			st_next.lvl = st_reg.s3;
		end
	end

	// State register
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_level = st_reg.lvl;

endmodule
